// >>> hdl/ccpu_map.vh
`ifndef CCPU_MAP_VH
`define CCPU_MAP_VH

// register offsets on the plain register port
`define CCPU_ADDR_W          3
`define CCPU_OFS_MODE_CTRL   3'h0
`define CCPU_OFS_DUTY_LOW    3'h1
`define CCPU_OFS_DUTY_HIGH   3'h2
`define CCPU_OFS_PERIOD      3'h3
`define CCPU_OFS_T2_COUNT    3'h4
`define CCPU_OFS_T2_CTRL     3'h5
`define CCPU_OFS_STATUS      3'h6

// unit_mode_control fields
`define CCPU_MODE_LSB        0
`define CCPU_MODE_MSB        3
`define CCPU_DLB_LSB         4
`define CCPU_DLB_MSB         5

// second_timer_control fields
`define CCPU_T2_PS_LSB       0
`define CCPU_T2_PS_MSB       1
`define CCPU_T2_ON_BIT       2

// status fields
`define CCPU_ST_FLAG_BIT     0
`define CCPU_ST_LEVEL_BIT    1
`define CCPU_ST_DRIVE_BIT    2
`define CCPU_ST_PEND_BIT     3

// mode_select_field encodings
`define CCPU_M_OFF           4'h0
`define CCPU_M_TOGGLE        4'h2
`define CCPU_M_CAP_FALL      4'h4
`define CCPU_M_CAP_RISE      4'h5
`define CCPU_M_CAP_RISE4     4'h6
`define CCPU_M_CAP_RISE16    4'h7
`define CCPU_M_SET           4'h8
`define CCPU_M_CLEAR         4'h9
`define CCPU_M_SOFT          4'ha
`define CCPU_M_SPECIAL       4'hb

// capture prescale terminal counts
`define CCPU_CAP_DIV4_LAST   4'h3
`define CCPU_CAP_DIV16_LAST  4'hf

// second timer prescale terminal counts, in system clocks (4 clocks per increment at prescale 1, 16 at 4, 64 at 16)
`define CCPU_PS1_LAST        6'h03
`define CCPU_PS4_LAST        6'h0f
`define CCPU_PS16_LAST       6'h3f

// reset values
`define CCPU_RST_BYTE        8'h00
`define CCPU_RST_PERIOD      8'hff

`endif

// >>> hdl/ccpu_sync.v
module ccpu_sync (
  // clock and reset
  input  wire ref_clk,
  input  wire rstn,
  // level in and out
  input  wire din,
  output reg  dout
);

  reg stage1;

  // stage1 is read by the second flop only
  always @(posedge ref_clk) begin
    if (!rstn) begin
      stage1 <= 1'b0;
      dout   <= 1'b0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule // ccpu_sync

// >>> hdl/ccpu_top.v
// Summary of operation
// - capture edge prescaler clears when off, outside capture, and on reset.
// - switching prescale directly keeps count; zero the mode register first.
// - compare mode matches 16-bit pair against first timer, then acts.
// - every compare mode sets the event flag on a match.
// - writing zero to mode register forces compare output latch low.
// - mode 1010 only flags the match and leaves the pin alone.
// - mode 1011 resets first timer, starts conversion if enabled, no pin.
// - special trigger fires at once; timer clear waits for timer clock edge.
// - special trigger never sets the first timer overflow flag.
// - rewriting match pair between trigger and timer edge cancels the reset.
// - writing zero to mode register in PWM releases the pin.
// - after timer equals period: clear timer, set output unless zero, load duty.
// - second timer postscaler has no effect on PWM period.
// - 10-bit duty: eight bits in duty low register, two in control.
// - duty double-buffered; duty high buffer read-only while in PWM.
// - time base is timer count plus two low bits from clock or prescaler.
// - time base equal to buffered duty drives the output low.
// - pulse width beyond period leaves the output level unchanged.
// - period (period+1)*4*prescale clocks; high time duty*prescale clocks.
// - in sleep the timer and unit freeze; pin holds its level.
// - capture event copies first timer count to pair and sets flag.
// - capture modes: falling, rising, every 4th rising, every 16th rising.
// - compare 0010 toggles, 1000 sets, 1001 clears the pin; all flag.
// - mode 0000 turns unit off; 1100 to 1111 select PWM polarities.
//
// Our own choices: the register addresses and the strobed register port.
`include "ccpu_map.vh"

module ccpu_top #(
  parameter TIMER_W = 16,
  parameter BYTE_W  = 8
) (
  // clock and reset
  input  wire                ref_clk,
  input  wire                rstn,
  // register port
  input  wire [2:0]          reg_addr,
  input  wire [BYTE_W-1:0]   reg_wdata,
  input  wire                reg_wr,
  input  wire                reg_rd,
  output reg  [BYTE_W-1:0]   reg_rdata,
  // first timer
  input  wire [TIMER_W-1:0]  first_timer_count,
  input  wire                first_timer_tick,
  output reg                 first_timer_reset,
  // converter
  input  wire                adc_enabled,
  output reg                 adc_start,
  // power state
  input  wire                sleep,
  // event flag
  output reg                 unit_event_flag,
  // shared_event_pin
  input  wire                pin_in,
  output reg                 pin_out,
  output reg                 pin_oe_n
);

  reg  [BYTE_W-1:0]  unit_mode_control;
  reg  [BYTE_W-1:0]  duty_low_register;
  reg  [BYTE_W-1:0]  duty_high_buffer;
  reg  [1:0]         duty_latch;
  reg  [BYTE_W-1:0]  pwm_period_register;
  reg  [BYTE_W-1:0]  second_timer_count;
  reg  [BYTE_W-1:0]  second_timer_control;
  reg  [5:0]         t2_prescale;
  reg  [3:0]         cap_prescale;
  reg                pin_prev;
  reg                cmp_latch;
  reg                pwm_level;
  reg                match_prev;
  reg                special_pend;
  wire               pin_sync;

  wire [3:0] mode_select_field = unit_mode_control[`CCPU_MODE_MSB:`CCPU_MODE_LSB];
  wire [1:0] duty_low_bits     = unit_mode_control[`CCPU_DLB_MSB:`CCPU_DLB_LSB];
  wire [1:0] t2_ps_sel = second_timer_control[`CCPU_T2_PS_MSB:`CCPU_T2_PS_LSB];
  wire       t2_on     = second_timer_control[`CCPU_T2_ON_BIT];
  wire       awake     = ~sleep;

  wire is_capture = (mode_select_field[3:2] == 2'b01);
  wire is_pwm     = (mode_select_field[3:2] == 2'b11);
  wire is_compare = (mode_select_field == `CCPU_M_TOGGLE) ||
                    (mode_select_field[3:2] == 2'b10);
  wire drives_cmp = (mode_select_field == `CCPU_M_TOGGLE) ||
                    (mode_select_field == `CCPU_M_SET) ||
                    (mode_select_field == `CCPU_M_CLEAR);

  wire wr_mode  = reg_wr && (reg_addr == `CCPU_OFS_MODE_CTRL);
  wire wr_low   = reg_wr && (reg_addr == `CCPU_OFS_DUTY_LOW);
  wire wr_high  = reg_wr && (reg_addr == `CCPU_OFS_DUTY_HIGH);
  wire wr_stat  = reg_wr && (reg_addr == `CCPU_OFS_STATUS);
  wire wr_t2cnt = reg_wr && (reg_addr == `CCPU_OFS_T2_COUNT);

  // event pin crosses into the clock domain first
  ccpu_sync u_pin_sync (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .din     (pin_in),
    .dout    (pin_sync)
  );

  // ---------------- capture ----------------
  wire rise = pin_sync & ~pin_prev;
  wire fall = ~pin_sync & pin_prev;
  reg  cap_event;

  always @* begin
    cap_event = 1'b0;
    case (mode_select_field)
      `CCPU_M_CAP_FALL:   cap_event = fall;
      `CCPU_M_CAP_RISE:   cap_event = rise;
      `CCPU_M_CAP_RISE4:  cap_event = rise && (cap_prescale[1:0] == `CCPU_CAP_DIV4_LAST);
      `CCPU_M_CAP_RISE16: cap_event = rise && (cap_prescale == `CCPU_CAP_DIV16_LAST);
      default:            cap_event = 1'b0;
    endcase
  end

  always @(posedge ref_clk) begin
    if (!rstn) begin
      pin_prev     <= 1'b0;
      cap_prescale <= 4'h0;
    end else if (awake) begin
      pin_prev <= pin_sync;
      if (!is_capture)
        cap_prescale <= 4'h0;
      else if (rise)
        cap_prescale <= cap_prescale + 4'h1;
    end
  end

  // ---------------- compare ----------------
  wire [TIMER_W-1:0] match_pair = {duty_high_buffer, duty_low_register};
  wire match_now  = (first_timer_count == match_pair);
  wire cmp_event  = is_compare && match_now && !match_prev && awake;
  wire special_ev = cmp_event && (mode_select_field == `CCPU_M_SPECIAL);

  always @(posedge ref_clk) begin
    if (!rstn)
      match_prev <= 1'b0;
    else if (awake)
      match_prev <= is_compare && match_now;
  end

  // latch forced low on zero write
  // toggle, set or clear on match
  always @(posedge ref_clk) begin
    if (!rstn) begin
      cmp_latch <= 1'b0;
    end else if (wr_mode && (reg_wdata == `CCPU_RST_BYTE)) begin
      cmp_latch <= 1'b0;
    end else if (cmp_event) begin
      case (mode_select_field)
        `CCPU_M_TOGGLE: cmp_latch <= ~cmp_latch;
        `CCPU_M_SET:    cmp_latch <= 1'b1;
        `CCPU_M_CLEAR:  cmp_latch <= 1'b0;
        default:        cmp_latch <= cmp_latch;
      endcase
    end
  end

  // timer clear waits for the timer tick
  // clear is its own strobe, never an overflow
  always @(posedge ref_clk) begin
    if (!rstn) begin
      special_pend      <= 1'b0;
      first_timer_reset <= 1'b0;
      adc_start         <= 1'b0;
    end else begin
      adc_start         <= special_ev && adc_enabled;
      first_timer_reset <= 1'b0;
      if (wr_low || wr_high || mode_select_field != `CCPU_M_SPECIAL) begin
        special_pend <= 1'b0;
      end else if (special_ev) begin
        special_pend <= 1'b1;
      end else if (special_pend && first_timer_tick && awake) begin
        special_pend      <= 1'b0;
        first_timer_reset <= 1'b1;
      end
    end
  end

  // ---------------- second timer and PWM ----------------
  reg [5:0] ps_last;
  reg [1:0] tb_low;
  reg       tb_step;

  // low bits from clock phase or prescaler
  always @* begin
    ps_last = `CCPU_PS1_LAST;
    tb_low  = t2_prescale[1:0];
    tb_step = 1'b1;
    case (t2_ps_sel)
      2'b00: begin
        ps_last = `CCPU_PS1_LAST;
        tb_low  = t2_prescale[1:0];
        tb_step = 1'b1;
      end
      2'b01: begin
        ps_last = `CCPU_PS4_LAST;
        tb_low  = t2_prescale[3:2];
        tb_step = (t2_prescale[1:0] == 2'b11);
      end
      default: begin
        ps_last = `CCPU_PS16_LAST;
        tb_low  = t2_prescale[5:4];
        tb_step = (t2_prescale[3:0] == 4'hf);
      end
    endcase
  end

  wire        t2_tick    = t2_on && awake && (t2_prescale == ps_last);
  wire        period_end = t2_tick && (second_timer_count == pwm_period_register);
  wire [9:0]  time_base  = {second_timer_count, tb_low};
  wire [9:0]  duty_buf   = {duty_high_buffer, duty_latch};
  wire [9:0]  duty_next  = {duty_low_register, duty_low_bits};
  // coming time base: the registered level then falls exactly on the duty count
  wire [9:0]  tb_next    = time_base + {9'h000, tb_step};

  // no postscaler in the period path
  // period is (period+1) ticks of 4*prescale clocks
  always @(posedge ref_clk) begin
    if (!rstn) begin
      t2_prescale        <= 6'h00;
      second_timer_count <= `CCPU_RST_BYTE;
    end else if (wr_t2cnt) begin
      second_timer_count <= reg_wdata;
    end else if (t2_on && awake) begin
      if (t2_prescale == ps_last)
        t2_prescale <= 6'h00;
      else
        t2_prescale <= t2_prescale + 6'h01;
      if (period_end)
        second_timer_count <= `CCPU_RST_BYTE;
      else if (t2_tick)
        second_timer_count <= second_timer_count + 8'h01;
    end
  end

  // pwm level is held low outside PWM mode, so every entry into PWM starts from low
  always @(posedge ref_clk) begin
    if (!rstn) begin
      pwm_level <= 1'b0;
    end else if (!is_pwm) begin
      pwm_level <= 1'b0;
    end else if (period_end) begin
      pwm_level <= (duty_next != 10'h000);
    end else if (awake && t2_on && (tb_next == duty_buf)) begin
      pwm_level <= 1'b0;
    end
  end

  // ---------------- registers ----------------
  // duty low writable any time except in a cycle with a capture event; duty high only outside PWM
  always @(posedge ref_clk) begin
    if (!rstn) begin
      unit_mode_control    <= `CCPU_RST_BYTE;
      duty_low_register    <= `CCPU_RST_BYTE;
      duty_high_buffer     <= `CCPU_RST_BYTE;
      duty_latch           <= 2'b00;
      pwm_period_register  <= `CCPU_RST_PERIOD;
      second_timer_control <= `CCPU_RST_BYTE;
    end else begin
      if (wr_mode)
        unit_mode_control <= reg_wdata;
      if (wr_low)
        duty_low_register <= reg_wdata;
      if (reg_wr && reg_addr == `CCPU_OFS_PERIOD)
        pwm_period_register <= reg_wdata;
      if (reg_wr && reg_addr == `CCPU_OFS_T2_CTRL)
        second_timer_control <= reg_wdata;
      if (cap_event && awake) begin
        duty_high_buffer  <= first_timer_count[15:8];
        duty_low_register <= first_timer_count[7:0];
      end else if (is_pwm && period_end) begin
        duty_high_buffer <= duty_low_register;
        duty_latch       <= duty_low_bits;
      end else if (wr_high && !is_pwm) begin
        duty_high_buffer <= reg_wdata;
      end
    end
  end

  // every compare mode flags a match
  // capture flags too; set wins over clear
  always @(posedge ref_clk) begin
    if (!rstn)
      unit_event_flag <= 1'b0;
    else if (cmp_event || (cap_event && awake))
      unit_event_flag <= 1'b1;
    else if (wr_stat && reg_wdata[`CCPU_ST_FLAG_BIT])
      unit_event_flag <= 1'b0;
  end

  // ---------------- pin ----------------
  // soft-interrupt mode leaves pin to the port
  // off mode releases; PWM polarity from mode bit 1
  always @(posedge ref_clk) begin
    if (!rstn) begin
      pin_out  <= 1'b0;
      pin_oe_n <= 1'b1;
    end else if (awake) begin
      if (is_pwm) begin
        pin_out  <= pwm_level ^ mode_select_field[1];
        pin_oe_n <= 1'b0;
      end else if (drives_cmp) begin
        pin_out  <= cmp_latch;
        pin_oe_n <= 1'b0;
      end else begin
        pin_out  <= 1'b0;
        pin_oe_n <= 1'b1;
      end
    end
  end

  // ---------------- read port ----------------
  always @(posedge ref_clk) begin
    if (!rstn) begin
      reg_rdata <= `CCPU_RST_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        `CCPU_OFS_MODE_CTRL: reg_rdata <= unit_mode_control;
        `CCPU_OFS_DUTY_LOW:  reg_rdata <= duty_low_register;
        `CCPU_OFS_DUTY_HIGH: reg_rdata <= duty_high_buffer;
        `CCPU_OFS_PERIOD:    reg_rdata <= pwm_period_register;
        `CCPU_OFS_T2_COUNT:  reg_rdata <= second_timer_count;
        `CCPU_OFS_T2_CTRL:   reg_rdata <= second_timer_control;
        `CCPU_OFS_STATUS:    reg_rdata <= {4'h0, special_pend, ~pin_oe_n,
                                           pwm_level, unit_event_flag};
        default:             reg_rdata <= `CCPU_RST_BYTE;
      endcase
    end else begin
      reg_rdata <= `CCPU_RST_BYTE;
    end
  end

endmodule // ccpu_top

// >>> tb/ccpu_chk_sva.sv
`include "ccpu_map.vh"
module ccpu_chk #(
  parameter TIMER_W = 16,
  parameter BYTE_W  = 8
) (
  // clock and reset
  input wire               ref_clk,
  input wire               rstn,
  // register port
  input wire [2:0]         reg_addr,
  input wire [BYTE_W-1:0]  reg_wdata,
  input wire               reg_wr,
  // timer, converter, power
  input wire [TIMER_W-1:0] first_timer_count,
  input wire               first_timer_tick,
  input wire               first_timer_reset,
  input wire               adc_enabled,
  input wire               adc_start,
  input wire               sleep,
  // flag and pin
  input wire               unit_event_flag,
  input wire               pin_in,
  input wire               pin_out,
  input wire               pin_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // mode and pair shadows; only valid while no capture overwrites the pair
  reg  [3:0]         mode;
  reg  [TIMER_W-1:0] pair;
  reg                hit_q;
  wire               cmp = mode == `CCPU_M_TOGGLE || mode[3:2] == 2'b10;
  wire               hit = cmp && first_timer_count == pair;
  // rising into equality, one event per match
  wire               hit_ev = hit && !hit_q && !sleep;
  always @(posedge ref_clk) begin
    if (!rstn) begin
      mode  <= 4'h0;
      pair  <= {TIMER_W{1'b0}};
      hit_q <= 1'b0;
    end else begin
      hit_q <= hit;
      if (reg_wr) begin
        if (reg_addr == `CCPU_OFS_MODE_CTRL)
          mode <= reg_wdata[3:0];
        if (reg_addr == `CCPU_OFS_DUTY_LOW)
          pair[7:0] <= reg_wdata[7:0];
        if (reg_addr == `CCPU_OFS_DUTY_HIGH)
          pair[TIMER_W-1:8] <= reg_wdata[7:0];
      end
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  property p_flag; hit_ev |=> unit_event_flag; endproperty
  property p_set; hit_ev && mode == 4'h8 |-> ##2 pin_out && !pin_oe_n; endproperty
  property p_clr; hit_ev && mode == 4'h9 |-> ##2 !pin_out && !pin_oe_n; endproperty
  property p_tog; hit_ev && mode == 4'h2 |-> ##2 pin_out != $past(pin_out); endproperty
  property p_adc; hit_ev && mode == 4'hb && adc_enabled |=> adc_start; endproperty
  property p_soft; mode[3:1] == 3'b101 && $past(mode) == mode |=> pin_oe_n; endproperty
  property p_trst; first_timer_reset |-> $past(first_timer_tick); endproperty
  property p_off;
    reg_wr && reg_addr == 3'h0 && reg_wdata == 8'h00 && !sleep |-> ##3 pin_oe_n && !pin_out;
  endproperty
  property p_sleep;
    sleep && $past(sleep) |-> $stable(pin_out) && $stable(pin_oe_n) && $stable(unit_event_flag);
  endproperty
  property p_cap; mode == 4'h5 && $rose(pin_in) |-> ##[2:6] unit_event_flag; endproperty
  a_flag: assert property (p_flag) else $error("no flag on match");
  a_set: assert property (p_set) else $error("pin not set on match");
  a_clr: assert property (p_clr) else $error("pin not cleared on match");
  a_tog: assert property (p_tog) else $error("pin not toggled on match");
  a_adc: assert property (p_adc) else $error("no conversion start");
  a_soft: assert property (p_soft) else $error("pin driven in no-pin mode");
  a_trst: assert property (p_trst) else $error("timer clear without tick");
  a_off: assert property (p_off) else $error("pin not released low");
  a_sleep: assert property (p_sleep) else $error("state moved in sleep");
  a_cap: assert property (p_cap) else $error("no capture flag");
  c_spec: cover property (hit_ev && mode == 4'hb);
  c_trst: cover property (first_timer_reset);
  c_sleep: cover property (sleep && !pin_oe_n);
endmodule // ccpu_chk

bind ccpu_top ccpu_chk #(.TIMER_W(TIMER_W), .BYTE_W(BYTE_W)) chk_u (
  .ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .first_timer_count, .first_timer_tick,
  .first_timer_reset, .adc_enabled, .adc_start, .sleep, .unit_event_flag, .pin_in,
  .pin_out, .pin_oe_n);

// >>> tb/ccpu_pin_src.sv
module ccpu_pin_src (
  // pin from the unit
  input  wire pin_out,
  input  wire pin_oe_n,
  // level commanded by the bench
  input  wire src_level,
  // pin seen by the unit
  output wire pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // released pin follows the source, a driven pin reads back its own level
  assign pin_in = pin_oe_n ? src_level : pin_out;
endmodule // ccpu_pin_src

// >>> tb/capture_compare_pwm_unit_test.sv
module capture_compare_pwm_unit_test;
  timeunit 1ns;
  timeprecision 1ns;
  reg         ref_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, tick = 0;
  reg         adc_enabled = 0, sleep = 0, src = 0, run = 0, t1_ld = 0;
  reg  [2:0]  reg_addr = 3'h0;
  reg  [7:0]  reg_wdata = 8'h00, rv;
  reg  [15:0] t1 = 16'h0000, t1_val = 16'h0000;
  reg  [1:0]  dv = 2'h0, ps;
  reg  [3:0]  m;
  wire [7:0]  reg_rdata;
  wire        t1_rst, adc_start, flag, pin_in, pin_out, pin_oe_n;
  integer     n_mismatch = 0, n_tests = 0, cyc = 0, i, n, hi, per, w;
  localparam [23:0] CM = 24'h892_2a8;
  localparam [11:0] CE = 12'b01_00_01_00_10_01;

  ccpu_top dut_u (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .first_timer_count(t1), .first_timer_tick(tick), .first_timer_reset(t1_rst),
    .adc_enabled, .adc_start, .sleep, .unit_event_flag(flag), .pin_in, .pin_out, .pin_oe_n);
  ccpu_pin_src src_u (.pin_out, .pin_oe_n, .src_level(src), .pin_in);

  initial forever #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    dv <= dv + 2'h1;
    tick <= run && dv == 2'h3;
    if (t1_ld)
      t1 <= t1_val;
    else if (t1_rst)
      t1 <= 16'h0000;
    else if (tick)
      t1 <= t1 + 16'h0001;
    if (cyc == 40000) begin
      n_mismatch = n_mismatch + 1;
      print_verdict;
    end
  end
  task print_verdict;
    begin
      if (n_mismatch == 0 && n_tests > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task automatic chk(input [15:0] seen, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task automatic wr(input [2:0] a, input [7:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task automatic rd(input [2:0] a);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #10 rv = reg_rdata;
      @(posedge ref_clk);
    end
  endtask
  task automatic wait_flag;
    integer k;
    begin
      k = 0;
      while (flag !== 1'b1 && k < 400) begin
        @(posedge ref_clk);
        k = k + 1;
      end
    end
  endtask
  // high cycles and rising edges over a window of whole periods
  task automatic sample(input integer len);
    reg last;
    begin
      hi = 0;
      per = 0;
      last = pin_out;
      repeat (len) begin
        @(posedge ref_clk);
        #10 hi = hi + pin_out;
        per = per + (pin_out & ~last);
        last = pin_out;
      end
    end
  endtask
  task automatic pulse;
    begin
      src <= 1'b1;
      repeat (8) @(posedge ref_clk);
      src <= 1'b0;
      repeat (8) @(posedge ref_clk);
    end
  endtask
  // timer loads go through the timer process, its only driver
  task automatic set_t1(input [15:0] v);
    begin
      t1_val <= v;
      t1_ld <= 1'b1;
      @(posedge ref_clk);
      t1_ld <= 1'b0;
    end
  endtask

  initial begin
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rd(3'h0); chk(rv, 8'h00);
    rd(3'h3); chk(rv, 8'hff);
    rd(3'h7); chk(rv, 8'h00);
    chk(pin_oe_n, 1'b1);
    // compare modes in turn, latch carried between modes
    for (i = 0; i < 6; i = i + 1) begin
      run <= 1'b0;
      set_t1(16'h0000);
      wr(3'h1, 8'h10);
      wr(3'h2, 8'h00);
      wr(3'h0, {4'h0, CM[23-4*i -: 4]});
      wr(3'h6, 8'h01);
      run <= 1'b1;
      wait_flag;
      repeat (3) @(posedge ref_clk);
      chk(flag, 1'b1);
      chk({pin_oe_n, pin_out}, CE[11-2*i -: 2]);
    end
    wr(3'h0, 8'h00);
    @(posedge ref_clk);
    chk({pin_oe_n, pin_out}, 2'b10);
    // special trigger clears the timer, then a pair rewrite cancels it
    adc_enabled <= 1'b1;
    wr(3'h1, 8'h20);
    wr(3'h0, 8'h0b);
    wr(3'h6, 8'h01);
    set_t1(16'h0000);
    wait_flag;
    repeat (12) @(posedge ref_clk);
    chk(t1 < 16'h0020, 1'b1);
    run <= 1'b0;
    set_t1(16'h0020);
    wait_flag;
    wr(3'h1, 8'h40);
    run <= 1'b1;
    repeat (12) @(posedge ref_clk);
    chk(t1 > 16'h0020, 1'b1);
    // capture: rising and falling edge, off between settings
    run <= 1'b0;
    for (i = 0; i < 2; i = i + 1) begin
      wr(3'h0, 8'h00);
      set_t1(i ? 16'h5678 : 16'h1234);
      wr(3'h0, i ? 8'h04 : 8'h05);
      wr(3'h6, 8'h01);
      src <= ~src;
      wait_flag;
      rd(3'h1); chk(rv, i ? 8'h78 : 8'h34);
      rd(3'h2); chk(rv, i ? 8'h56 : 8'h12);
    end
    // every 4th and every 16th rising edge
    for (i = 0; i < 2; i = i + 1) begin
      wr(3'h0, 8'h00);
      wr(3'h0, i ? 8'h07 : 8'h06);
      wr(3'h6, 8'h01);
      w = i ? 16 : 4;
      for (n = 1; n <= w; n = n + 1) begin
        pulse;
        rd(3'h6); chk(rv[0], n == w);
      end
    end
    // pwm: period 4 ticks, duty 6 quarter ticks, all prescales and polarities
    wr(3'h0, 8'h00);
    wr(3'h3, 8'h03);
    wr(3'h1, 8'h01);
    for (i = 0; i < 7; i = i + 1) begin
      ps = i < 3 ? i : 0;
      m = i < 3 ? 4'hc : 4'h9 + i;
      wr(3'h5, {5'h01, ps});
      wr(3'h0, {4'h2, m});
      w = 64 << (2 * ps);
      sample(w);
      sample(w);
      chk(hi, m[1] ? w - (24 << (2 * ps)) : 24 << (2 * ps));
      chk(per, 4);
    end
    wr(3'h0, 8'h2c);
    wr(3'h2, 8'h77);
    rd(3'h2); chk(rv, 8'h01);
    sleep <= 1'b1;
    wr(3'h4, 8'h02);
    repeat (20) @(posedge ref_clk);
    rd(3'h4); chk(rv, 8'h02);
    sleep <= 1'b0;
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h0c);
    sample(64);
    sample(64);
    chk(hi, 0);
    wr(3'h1, 8'hff);
    sample(64);
    sample(64);
    chk(hi, 64);
    wr(3'h0, 8'h00);
    @(posedge ref_clk);
    chk(pin_oe_n, 1'b1);
    print_verdict;
  end
endmodule // capture_compare_pwm_unit_test
